/* hw/term_pkg.sv */
package term_pkg;

  localparam int CLK_PERIOD_PS = 40000;
  localparam int TERM_ON_SETTLE_MIN_PS = 1500;
  localparam int TERM_ON_SETTLE_MAX_PS = 3500;
  localparam int TERM_OFF_SETTLE_MIN_PS = 1500;
  localparam int TERM_OFF_SETTLE_MAX_PS = 3500;
  localparam int ON_SETTLE_RAW = TERM_ON_SETTLE_MAX_PS / CLK_PERIOD_PS;
  localparam int OFF_SETTLE_RAW = TERM_OFF_SETTLE_MAX_PS / CLK_PERIOD_PS;
  localparam int TERM_ON_SETTLE_CYC = (ON_SETTLE_RAW < 1) ? 1 : ON_SETTLE_RAW;
  localparam int TERM_OFF_SETTLE_CYC =
    (OFF_SETTLE_RAW < 1) ? 1 : OFF_SETTLE_RAW;

  localparam int CFG_W = 8;
  localparam int CFG_EN_BIT = 3;
  localparam int CFG_RES_LSB = 0;
  localparam int RES_W = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] RES_CODE_MIN = 3'h1;
  localparam logic [2:0] RES_CODE_MAX = 3'h6;

  localparam int LAT_W = 6;
  localparam int BAND_W = 3;
  localparam logic [2:0] BAND_LAST = 3'h6;
  localparam logic [5:0] BL32_EXTRA = 6'h08;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_WRITE_FIRST = 3'b001,
    CMD_MASK_WRITE_FIRST = 3'b010,
    CMD_CAS_SECOND = 3'b011,
    CMD_MODE_WRITE = 3'b100
  } cmd_e;

  typedef enum logic [1:0] {
    TS_OFF = 2'b00,
    TS_TURN_ON = 2'b01,
    TS_ON = 2'b10,
    TS_TURN_OFF = 2'b11
  } term_state_e;

  // Zero marks a band where the latency is not defined.
  localparam logic [5:0] ON_LAT_A [0:6] =
    '{6'h00, 6'h00, 6'h00, 6'h04, 6'h04, 6'h06, 6'h06};
  localparam logic [5:0] ON_LAT_B [0:6] =
    '{6'h00, 6'h00, 6'h06, 6'h0C, 6'h0E, 6'h12, 6'h14};
  localparam logic [5:0] OFF_LAT_A [0:6] =
    '{6'h00, 6'h00, 6'h00, 6'h14, 6'h16, 6'h18, 6'h1A};
  localparam logic [5:0] OFF_LAT_B [0:6] =
    '{6'h00, 6'h00, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
  localparam logic [7:0] RES_OHMS [0:7] =
    '{8'h00, 8'hF0, 8'h78, 8'h50, 8'h3C, 8'h30, 8'h28, 8'h00};

endpackage : term_pkg

/* hw/term_sync2.sv */
`timescale 1ns/1ps
module term_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk, // Destination clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic [WIDTH-1:0] i_d, // Level from the other domain.
  output logic [WIDTH-1:0] o_q // Synchronised level.
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_d;
      sync_reg <= meta_reg;
    end
  end

  assign o_q = sync_reg;

endmodule : term_sync2

/* hw/term_latency_rom.sv */
`timescale 1ns/1ps
module term_latency_rom
  import term_pkg::*;
(
  input wire logic i_clk, // Link clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_set_b, // High selects latency set B.
  input wire logic [BAND_W-1:0] i_band, // Clock frequency band index.
  output logic [LAT_W-1:0] o_on_lat, // Turn-on latency in cycles.
  output logic [LAT_W-1:0] o_off_lat, // Burst-16 turn-off latency.
  output logic o_valid // Both latencies are defined.
);

  wire band_ok = (i_band <= BAND_LAST);
  wire [2:0] idx = band_ok ? i_band : 3'h0;
  wire [LAT_W-1:0] on_sel = i_set_b ? ON_LAT_B[idx] : ON_LAT_A[idx];
  wire [LAT_W-1:0] off_sel = i_set_b ? OFF_LAT_B[idx] : OFF_LAT_A[idx];
  wire ok_sel = band_ok && (on_sel != '0) && (off_sel != '0);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_on_lat <= '0;
      o_off_lat <= '0;
      o_valid <= 1'b0;
    end else begin
      o_on_lat <= on_sel;
      o_off_lat <= off_sel;
      o_valid <= ok_sel;
    end
  end

endmodule : term_latency_rom

/* hw/term_ctrl.sv */
`timescale 1ns/1ps
module term_ctrl
  import term_pkg::*;
#(
  parameter int LAT_WIDTH = LAT_W
) (
  input wire logic i_clk, // Core clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_ce, // Core clock enable.
  input wire logic i_link_clk, // Command clock from the controller.
  input wire logic i_cmd_valid, // Command present on this link edge.
  input wire logic [2:0] i_cmd, // Command code.
  input wire logic [CFG_W-1:0] i_cmd_operand, // Mode write operand bits.
  input wire logic i_wl_set_b, // Write latency set B selected.
  input wire logic [BAND_W-1:0] i_freq_band, // Clock frequency band.
  input wire logic i_bl32, // Burst length 32 in use.
  input wire logic i_write_leveling, // Write leveling mode.
  input wire logic i_power_down, // Power-down state.
  input wire logic i_self_refresh, // Self-refresh state.
  output logic o_dq_term_en, // Data pin termination switch.
  output logic o_mask_inv_term_en, // Mask/inversion pin termination.
  output logic o_strobe_term_en, // Strobe pair termination switch.
  output logic [RES_W-1:0] o_term_resistance, // Selected resistance code.
  output logic [7:0] o_term_ohms, // Selected resistance in ohms.
  output logic [CFG_W-1:0] o_config_readback, // Termination config value.
  output logic o_latency_invalid, // Write seen with undefined latency.
  output logic [1:0] o_term_state, // Core view of settle state.
  output logic o_term_fully_on, // Termination settled on.
  output logic o_term_mode_enabled, // Mode enable seen in core.
  output logic o_write_window // Write window seen in core.
);

  generate
    if (LAT_WIDTH < LAT_W) begin : g_bad_width
      $error("term_ctrl: LAT_WIDTH too small for the latency table");
    end
  endgenerate

  // Link-side command capture. These pins are synchronous to the link
  // clock, so one register stage is enough.

  logic cmd_valid_reg;
  logic [2:0] cmd_reg;
  logic [CFG_W-1:0] operand_reg;
  logic wl_reg;
  logic pd_reg;
  logic sr_reg;
  logic bl32_reg;

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_valid_reg <= 1'b0;
      cmd_reg <= CMD_NOP;
      operand_reg <= CFG_RESET;
    end else begin
      cmd_valid_reg <= i_cmd_valid;
      cmd_reg <= i_cmd;
      operand_reg <= i_cmd_operand;
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      wl_reg <= 1'b0;
      pd_reg <= 1'b0;
      sr_reg <= 1'b0;
      bl32_reg <= 1'b0;
    end else begin
      wl_reg <= i_write_leveling;
      pd_reg <= i_power_down;
      sr_reg <= i_self_refresh;
      bl32_reg <= i_bl32;
    end
  end

  wire is_mode_wr = cmd_valid_reg && (cmd_reg == CMD_MODE_WRITE);
  wire is_cas2 = cmd_valid_reg && (cmd_reg == CMD_CAS_SECOND);
  wire is_wr1 = cmd_valid_reg &&
    ((cmd_reg == CMD_WRITE_FIRST) || (cmd_reg == CMD_MASK_WRITE_FIRST));

  // Termination configuration register.

  logic [CFG_W-1:0] cfg_reg;
  wire [CFG_W-1:0] cfg_next = is_mode_wr ? operand_reg : cfg_reg;

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // A non-zero field with bit 3 clear is treated as disabled: the
  // disable condition is the narrower one and wins.
  wire cfg_nonzero = |cfg_reg[CFG_EN_BIT:0];
  wire cfg_en_bit = cfg_reg[CFG_EN_BIT];
  wire mode_en = cfg_nonzero && cfg_en_bit;
  wire [RES_W-1:0] res_code = cfg_reg[CFG_RES_LSB +: RES_W];
  wire res_ok = (res_code >= RES_CODE_MIN) && (res_code <= RES_CODE_MAX);
  wire low_power = pd_reg || sr_reg;
  wire term_usable = mode_en && res_ok && !low_power;

  // Latency lookup for the current set and band.

  wire [LAT_W-1:0] rom_on_lat;
  wire [LAT_W-1:0] rom_off_lat;
  wire rom_valid;

  term_latency_rom u_rom (
    .i_clk(i_link_clk),
    .i_rst(i_rst),
    .i_set_b(i_wl_set_b),
    .i_band(i_freq_band),
    .o_on_lat(rom_on_lat),
    .o_off_lat(rom_off_lat),
    .o_valid(rom_valid)
  );

  wire [LAT_W-1:0] off_extra = bl32_reg ? BL32_EXTRA : '0;
  wire [LAT_W-1:0] off_lat_eff = rom_off_lat + off_extra;

  // A first write command arms the window; its second column command
  // is the reference point of both latencies.

  logic armed_reg;
  wire armed_next = is_wr1 ? 1'b1 : (is_cas2 ? 1'b0 : armed_reg);

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end

  wire write_ref = is_cas2 && armed_reg;
  wire start = write_ref && term_usable && rom_valid && !wl_reg;
  wire lat_bad = write_ref && mode_en && !rom_valid;

  logic [LAT_W-1:0] on_lat_reg;
  logic [LAT_W-1:0] off_lat_reg;

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      on_lat_reg <= '0;
      off_lat_reg <= '0;
    end else if (start) begin
      on_lat_reg <= rom_on_lat;
      off_lat_reg <= off_lat_eff;
    end
  end

  // Window counter. The count is 1 on the edge after the reference
  // command, so a latency of N lands on the Nth edge after it. A new
  // write restarts the count; an open window stays open across it.

  logic busy_reg;
  logic [LAT_W-1:0] cnt_reg;
  logic win_reg;

  wire kill = low_power || !mode_en || wl_reg;
  wire on_hit = busy_reg && (cnt_reg == on_lat_reg);
  wire off_hit = busy_reg && (cnt_reg == off_lat_reg);
  wire [LAT_W-1:0] cnt_inc = cnt_reg + 6'h01;

  wire [LAT_W-1:0] cnt_next = start ? 6'h01 : (busy_reg ? cnt_inc : cnt_reg);
  wire busy_next = kill ? 1'b0 :
    (start ? 1'b1 : (off_hit ? 1'b0 : busy_reg));
  wire win_next = kill ? 1'b0 :
    ((off_hit && !start) ? 1'b0 : (on_hit ? 1'b1 : win_reg));

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      busy_reg <= busy_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      win_reg <= 1'b0;
    end else begin
      win_reg <= win_next;
    end
  end

  // Pin switch enables.

  wire dq_term_next = win_reg && !wl_reg && term_usable;
  wire leveling_strobe = wl_reg && term_usable;
  wire strobe_term_next = dq_term_next || leveling_strobe;

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dq_term_en <= 1'b0;
      o_mask_inv_term_en <= 1'b0;
      o_strobe_term_en <= 1'b0;
    end else begin
      o_dq_term_en <= dq_term_next;
      o_mask_inv_term_en <= dq_term_next;
      o_strobe_term_en <= strobe_term_next;
    end
  end

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      o_term_resistance <= '0;
      o_term_ohms <= '0;
      o_config_readback <= CFG_RESET;
    end else begin
      o_term_resistance <= res_code;
      o_term_ohms <= RES_OHMS[res_code];
      o_config_readback <= cfg_reg;
    end
  end

  // Sticky: a new bad write in the same cycle as a mode write keeps
  // the flag set.
  wire lat_flag_next = lat_bad ? 1'b1 :
    (is_mode_wr ? 1'b0 : o_latency_invalid);

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      o_latency_invalid <= 1'b0;
    end else begin
      o_latency_invalid <= lat_flag_next;
    end
  end

  // Levels handed to the core domain come from flip-flops only.

  logic mode_en_reg;

  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_en_reg <= 1'b0;
    end else begin
      mode_en_reg <= mode_en;
    end
  end

  wire [1:0] core_levels;

  term_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({mode_en_reg, o_dq_term_en}),
    .o_q(core_levels)
  );

  wire core_mode_en = core_levels[1];
  wire core_win = core_levels[0];

  // Core-side settle tracker. The analogue turn-on and turn-off take at
  // most a few nanoseconds, far below one core period, so the tracker
  // only reports when the switch may be taken as settled.

  term_state_e state_reg;
  term_state_e state_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;

  localparam logic [1:0] ON_SETTLE = 2'(TERM_ON_SETTLE_CYC);
  localparam logic [1:0] OFF_SETTLE = 2'(TERM_OFF_SETTLE_CYC);

  wire settle_done = (settle_reg == 2'h1);
  wire [1:0] settle_dec = settle_reg - 2'h1;

  always_comb begin
    state_next = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      TS_OFF: begin
        if (core_win) begin
          state_next = TS_TURN_ON;
          settle_next = ON_SETTLE;
        end
      end
      TS_TURN_ON: begin
        if (!core_win) begin
          state_next = TS_TURN_OFF;
          settle_next = OFF_SETTLE;
        end else if (settle_done) begin
          state_next = TS_ON;
        end else begin
          settle_next = settle_dec;
        end
      end
      TS_ON: begin
        if (!core_win) begin
          state_next = TS_TURN_OFF;
          settle_next = OFF_SETTLE;
        end
      end
      TS_TURN_OFF: begin
        if (core_win) begin
          state_next = TS_TURN_ON;
          settle_next = ON_SETTLE;
        end else if (settle_done) begin
          state_next = TS_OFF;
        end else begin
          settle_next = settle_dec;
        end
      end
      default: begin
        state_next = TS_OFF;
        settle_next = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= TS_OFF;
      settle_reg <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
      settle_reg <= settle_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_term_state <= TS_OFF;
      o_term_fully_on <= 1'b0;
      o_term_mode_enabled <= 1'b0;
      o_write_window <= 1'b0;
    end else if (i_ce) begin
      o_term_state <= state_next;
      o_term_fully_on <= (state_next == TS_ON);
      o_term_mode_enabled <= core_mode_en;
      o_write_window <= core_win;
    end
  end

endmodule : term_ctrl

/* sim/mem_ctrl_model.sv */
`timescale 1ns/1ps
module mem_ctrl_model
  import term_pkg::*;
(
  input wire logic i_link_clk, // Command clock, free running.
  output logic o_cmd_valid, // Command present.
  output logic [2:0] o_cmd, // Command code.
  output logic [CFG_W-1:0] o_operand // Mode write operand.
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = CMD_NOP;
    o_operand = 8'h00;
  end

  // Released lines show the inverse of the last value, so a design that
  // decodes without the valid qualifier sees a wrong command.
  task automatic issue(input logic [2:0] c, input logic [7:0] op);
    @(posedge i_link_clk);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    o_operand <= op;
    @(posedge i_link_clk);
    o_cmd_valid <= 1'b0;
    o_cmd <= ~c;
    o_operand <= ~op;
  endtask : issue

  task automatic mode_write(input logic [7:0] op);
    issue(CMD_MODE_WRITE, op);
  endtask : mode_write

  // The gap between the two halves of a write may be any length.
  task automatic write(input logic masked, input int gap);
    issue(masked ? CMD_MASK_WRITE_FIRST : CMD_WRITE_FIRST, 8'h00);
    repeat (gap) @(posedge i_link_clk);
    issue(CMD_CAS_SECOND, 8'h00);
  endtask : write
endmodule : mem_ctrl_model

/* sim/term_ctrl_properties.sv */
`timescale 1ns/1ps
module term_ctrl_checker
  import term_pkg::*;
(
  input wire logic i_clk, // Core clock.
  input wire logic i_rst, // Reset, both domains.
  input wire logic i_ce, // Core clock enable.
  input wire logic i_link_clk, // Command clock.
  input wire logic i_cmd_valid, // Command present.
  input wire logic [2:0] i_cmd, // Command code.
  input wire logic i_write_leveling, // Write leveling mode.
  input wire logic i_power_down, // Power-down state.
  input wire logic i_self_refresh, // Self-refresh state.
  input wire logic o_dq_term_en, // Data termination.
  input wire logic o_mask_inv_term_en, // Mask pin termination.
  input wire logic o_strobe_term_en, // Strobe termination.
  input wire logic [RES_W-1:0] o_term_resistance, // Resistance code.
  input wire logic [7:0] o_term_ohms, // Resistance in ohms.
  input wire logic [CFG_W-1:0] o_config_readback, // Config copy.
  input wire logic [1:0] o_term_state // Core settle state.
);
  // Saturates so that a long idle spell cannot wrap into a legal latency.
  logic [6:0] since_cas_reg;
  logic [6:0] since_cas_next;
  logic quiet;
  assign since_cas_next = (i_cmd_valid && i_cmd == CMD_CAS_SECOND) ? 7'h00 :
    (since_cas_reg == 7'h7F) ? since_cas_reg : since_cas_reg + 7'h01;
  assign quiet = !i_power_down && !i_self_refresh && !i_write_leveling &&
    o_config_readback[3];
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      since_cas_reg <= 7'h7F;
    end else begin
      since_cas_reg <= since_cas_next;
    end
  end

  on_latency_a:
    assert property (@(posedge i_link_clk) disable iff (i_rst)
      $rose(o_dq_term_en) |->
        since_cas_reg inside {7'h06, 7'h08, 7'h0E, 7'h10, 7'h14, 7'h16})
    else $error("data termination rose at a wrong latency");
  off_latency_a:
    assert property (@(posedge i_link_clk) disable iff (i_rst)
      $fell(o_dq_term_en) && quiet && $past(quiet) |->
        since_cas_reg inside {[7'h16:7'h32]} && !since_cas_reg[0])
    else $error("data termination fell at a wrong latency");
  pin_group_a:
    assert property (@(posedge i_link_clk) disable iff (i_rst)
      (o_mask_inv_term_en == o_dq_term_en) &&
        (!o_dq_term_en || o_strobe_term_en))
    else $error("termination pins disagree");
  ohms_map_a:
    assert property (@(posedge i_link_clk) disable iff (i_rst)
      (o_term_resistance inside {[3'h1:3'h6]}) ?
        ({8'h00, o_term_ohms} * o_term_resistance == 16'h00F0) :
        (o_term_ohms == 8'h00))
    else $error("resistance value does not match its code");
  mode_off_a:
    assert property (@(posedge i_link_clk) disable iff (i_rst)
      (!o_config_readback[3]) [*3] |-> !o_dq_term_en && !o_strobe_term_en)
    else $error("termination active with mode disabled");
  low_power_a:
    assert property (@(posedge i_link_clk) disable iff (i_rst)
      (i_power_down || i_self_refresh) [*4] |->
        !o_dq_term_en && !o_strobe_term_en)
    else $error("termination active in a low power state");
  leveling_dq_a:
    assert property (@(posedge i_link_clk) disable iff (i_rst)
      i_write_leveling [*4] |-> !o_dq_term_en)
    else $error("data termination on during write leveling");
  leveling_strobe_a:
    assert property (@(posedge i_link_clk) disable iff (i_rst)
      (i_write_leveling && o_config_readback[3] &&
        !i_power_down && !i_self_refresh &&
        o_term_resistance inside {[3'h1:3'h6]}) [*4] |-> o_strobe_term_en)
    else $error("strobes unterminated during write leveling");
  settle_on_a:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_term_state == TS_TURN_ON && i_ce |=> o_term_state == TS_ON)
    else $error("turn-on settle longer than one cycle");
  settle_off_a:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_term_state == TS_TURN_OFF && i_ce |=> o_term_state == TS_OFF)
    else $error("turn-off settle longer than one cycle");
endmodule : term_ctrl_checker

bind term_ctrl term_ctrl_checker chk_u (.i_clk, .i_rst, .i_ce, .i_link_clk,
  .i_cmd_valid, .i_cmd, .i_write_leveling, .i_power_down, .i_self_refresh,
  .o_dq_term_en, .o_mask_inv_term_en, .o_strobe_term_en, .o_term_resistance,
  .o_term_ohms, .o_config_readback, .o_term_state);

/* sim/test_term_ctrl.sv */
`timescale 1ns/1ps
module test_term_ctrl;
  logic clk, link_clk, rst, ce, set_b, bl32, lev, pd, sr, cmd_valid;
  logic dq_en, mask_en, strobe_en, lat_inv, fully_on, mode_en, win;
  logic [2:0] band, cmd, res;
  logic [7:0] operand, ohms, readback;
  logic [1:0] state;
  int errors = 0;
  int checks_done = 0;

  mem_ctrl_model ctl_u (.i_link_clk(link_clk), .o_cmd_valid(cmd_valid),
    .o_cmd(cmd), .o_operand(operand));
  term_ctrl dut_u (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_link_clk(link_clk), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_cmd_operand(operand), .i_wl_set_b(set_b), .i_freq_band(band),
    .i_bl32(bl32), .i_write_leveling(lev), .i_power_down(pd),
    .i_self_refresh(sr), .o_dq_term_en(dq_en),
    .o_mask_inv_term_en(mask_en), .o_strobe_term_en(strobe_en),
    .o_term_resistance(res), .o_term_ohms(ohms),
    .o_config_readback(readback), .o_latency_invalid(lat_inv),
    .o_term_state(state), .o_term_fully_on(fully_on),
    .o_term_mode_enabled(mode_en), .o_write_window(win));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The offset keeps the link edges clear of the core edges.
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask : tick

  task automatic cfg(input logic sb, input logic [2:0] bd, input logic b32);
    @(posedge link_clk);
    set_b <= sb;
    band <= bd;
    bl32 <= b32;
  endtask : cfg

  task automatic run_write(input logic sb, input logic [2:0] bd,
      input logic b32, input logic m, input int on, input int off);
    int n;
    cfg(sb, bd, b32);
    ctl_u.write(m, 2);
    n = 0;
    while (dq_en !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    check(8'(n), 8'(on + 2));
    check({5'h00, dq_en, mask_en, strobe_en}, 8'h07);
    n = 0;
    while (dq_en === 1'b1 && n < 80) begin
      tick(1);
      n++;
      if (n == 3) begin
        check({4'h0, state, fully_on, win}, 8'h0B);
      end
    end
    check(8'(n), 8'(off - on));
    // The core copy needs two sync stages and two settle steps.
    tick(1);
    check({4'h0, state, fully_on, win}, 8'h00);
  endtask : run_write

  initial begin
    #300000;
    errors++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    set_b = 1'b0;
    band = 3'h3;
    bl32 = 1'b0;
    lev = 1'b0;
    pd = 1'b0;
    sr = 1'b0;
    repeat (2) @(posedge link_clk);
    rst <= 1'b0;
    tick(1);
    check(readback, 8'h00);
    for (int c = 1; c <= 6; c++) begin
      ctl_u.mode_write(8'h08 | 8'(c));
      // The core mirror of the mode enable trails by three core edges.
      tick(3);
      check({5'h00, res}, 8'(c));
      check(ohms, 8'(8'hF0 / c));
      check({7'h00, mode_en}, 8'h01);
    end
    run_write(1'b0, 3'h3, 1'b0, 1'b0, 4, 20);
    run_write(1'b0, 3'h6, 1'b0, 1'b1, 6, 26);
    run_write(1'b1, 3'h2, 1'b0, 1'b1, 6, 22);
    run_write(1'b1, 3'h6, 1'b1, 1'b0, 20, 48);
    run_write(1'b1, 3'h4, 1'b1, 1'b1, 14, 40);
    // A band without a defined latency must refuse the write.
    cfg(1'b0, 3'h2, 1'b0);
    ctl_u.write(1'b0, 0);
    tick(30);
    check({6'h00, dq_en, lat_inv}, 8'h01);
    ctl_u.mode_write(8'h0F);
    tick(2);
    check({7'h00, lat_inv}, 8'h00);
    cfg(1'b0, 3'h3, 1'b0);
    // Resistance code 7 leaves the mode bit set but selects no value.
    ctl_u.write(1'b0, 0);
    tick(30);
    check({6'h00, dq_en, strobe_en}, 8'h00);
    check(ohms, 8'h00);
    ctl_u.mode_write(8'h0E);
    tick(2);
    for (int k = 0; k < 2; k++) begin
      ctl_u.write(1'b0, 1);
      tick(8);
      @(posedge link_clk);
      pd <= (k == 0);
      sr <= (k == 1);
      tick(4);
      check({5'h00, dq_en, mask_en, strobe_en}, 8'h00);
      tick(30);
      @(posedge link_clk);
      pd <= 1'b0;
      sr <= 1'b0;
    end
    // With the core enable low the core view must hold still.
    @(posedge clk);
    ce <= 1'b0;
    ctl_u.write(1'b0, 0);
    tick(10);
    check({5'h00, dq_en, win, fully_on}, 8'h04);
    @(posedge clk);
    ce <= 1'b1;
    tick(20);
    @(posedge link_clk);
    lev <= 1'b1;
    tick(4);
    check({6'h00, strobe_en, dq_en}, 8'h02);
    ctl_u.mode_write(8'h04);
    tick(4);
    check({6'h00, strobe_en, dq_en}, 8'h00);
    @(posedge link_clk);
    lev <= 1'b0;
    ctl_u.write(1'b1, 0);
    tick(30);
    check({6'h00, dq_en, mode_en}, 8'h00);
    end_sim();
  end
endmodule : test_term_ctrl
